// ==== fpec_pkg.sv ====
// Package for the flash program/erase control block: register offsets,
// field positions and reset values.
// Assumes a plain strobe register port with 8-bit data.
`default_nettype none
package fpec_pkg;
   localparam int         ADDR_W            = 3;
   localparam int         DATA_W            = 8;
   // Register offsets on the plain register port.
   localparam logic [2:0] OFF_MODE_CTRL     = 3'h0;
   localparam logic [2:0] OFF_ERR_STATUS    = 3'h1;
   localparam logic [2:0] OFF_ERASE_BLOCK   = 3'h2;
   localparam logic [2:0] OFF_POWER_CTRL    = 3'h3;
   localparam logic [2:0] OFF_ACCESS_GATE   = 3'h4;
   localparam logic [2:0] OFF_ERR_INJECT    = 3'h5;
   // Field positions in the mode control register.
   localparam int         BIT_WRITE_UNLOCK  = 6;
   localparam int         BIT_ERASE_SETUP   = 5;
   localparam int         BIT_PROG_SETUP    = 4;
   localparam int         BIT_ERASE_VERIFY  = 3;
   localparam int         BIT_PROG_VERIFY   = 2;
   localparam int         BIT_ERASE_GO      = 1;
   localparam int         BIT_PROG_GO       = 0;
   // Field positions in the status, power and gate registers, and the block select width.
   localparam int         BIT_ERROR_FLAG    = 7;
   localparam int         BIT_UNLOCK_REGS   = 7;
   localparam int         BIT_PDOWN_DIS     = 7;
   localparam int         EBLK_W            = 7;
   // Reset values.
   localparam logic [7:0] RST_MODE_CTRL     = 8'h00;
   localparam logic [6:0] RST_ERASE_BLOCK   = 7'h00;
   localparam logic [7:0] READ_UNMAPPED     = 8'h00;
endpackage
`default_nettype wire

// ==== fpec_onehot_guard.sv ====
// Small checker that tells whether a block selection holds at most one bit.
// Assumes purely combinational use inside the control block.
`default_nettype none
module fpec_onehot_guard
   import fpec_pkg::*;
#(
   parameter int W = EBLK_W
) (
   input  wire logic [W-1:0] sel_in,
   output logic              multi_out
);
   // Clearing the lowest set bit leaves something only if two or more were set.
   always_comb begin
      multi_out = |(sel_in & (sel_in - W'(1)));
   end
endmodule
`default_nettype wire

// ==== fpec_ctrl.sv ====
// Flash program/erase control and status logic with its register port.
// Assumes one clock, an async active-low reset and a master that never waits.
//
// What this block does
// RQ1: Programming and erasing are allowed only while write-unlock (bit 6) is 1.
// RQ2: With write-unlock 0, other mode bits and block select bits cannot be set.
// RQ3: Erase-setup bit 5 enters erase setup state; clearing it cancels.
// RQ4: Software sets erase-setup before erase-go.
// RQ5: Program-setup bit 4 enters program setup state; clearing it cancels.
// RQ6: Software sets program-setup before program-go.
// RQ7: Erase-verify bit 3 enters erase-verify mode; clearing it leaves.
// RQ8: Program-verify bit 2 enters program-verify mode; clearing it leaves.
// RQ9: Erase-go bit 1 enters erase mode only with unlock and erase-setup set.
// RQ10: Program-go bit 0 enters program mode only with unlock and program-setup.
// RQ11: An error in a program or erase sets the error flag, status bit 7.
// RQ12: A set error flag puts the flash in error-protection state.
// RQ13: Software never writes the status register.
// RQ14: Mode control bit 7 always reads 0.
// RQ15: Status bits 6 to 0 always read 0.
// RQ16: Control register accesses work only while the gate unlock bit is 1.
// RQ17: Block select register is held at zero while write-unlock is 0.
// RQ18: Setting several block select bits at once clears all of them.
// RQ19: Reset clears every mode control bit and the error flag.
// RQ20: Error protection blocks entry into program and erase modes.
//
// Our own choices: the strobed register port and the register addresses.
`default_nettype none
module fpec_ctrl
   import fpec_pkg::*;
(
   input  wire logic              mclk_in,
   input  wire logic              rst_n_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [DATA_W-1:0] wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   input  wire logic              flash_fault_in,
   output logic [DATA_W-1:0]      rdata_out,
   output logic                   erase_setup_out,
   output logic                   program_setup_out,
   output logic                   erase_verify_out,
   output logic                   program_verify_out,
   output logic                   erase_mode_out,
   output logic                   program_mode_out,
   output logic [EBLK_W-1:0]      erase_block_out,
   output logic                   error_protect_out,
   output logic                   power_down_disable_out
);
   logic [6:0]        mode_reg;
   logic [EBLK_W-1:0] eblk_reg;
   logic              err_reg;
   logic              gate_reg;
   logic              pwr_reg;
   logic              fault_s1_reg;
   logic              fault_s2_reg;
   logic              multi_sel;
   logic              wr_mode;
   logic              wr_eblk;
   logic              wr_gated;
   logic              unlock;
   logic [6:0]        mode_next;
   logic              error_event;

   // The access gate hides every control register; one helper keeps the read mux uniform.
   function automatic logic [DATA_W-1:0] gated_read(input logic              gate_open,
                                                    input logic [DATA_W-1:0] value);
      return gate_open ? value : READ_UNMAPPED;
   endfunction

   // Second file: detects an illegal multi-block selection in the write data.
   fpec_onehot_guard #(
      .W         (EBLK_W)
   ) u_guard (
      .sel_in    (wdata_in[EBLK_W-1:0]),
      .multi_out (multi_sel)
   );

   // The access gate register itself is always reachable, or it could never open.
   assign wr_gated = wr_in & gate_reg;                                    // RQ16
   assign wr_mode  = wr_gated & (addr_in == OFF_MODE_CTRL);
   assign wr_eblk  = wr_gated & (addr_in == OFF_ERASE_BLOCK);
   assign unlock   = mode_reg[BIT_WRITE_UNLOCK];

   // Mode write filter: the go bits only take when their setup bit and unlock
   // hold in the written value and the setup bit was already set before the
   // write, so a single write cannot skip the setup phase.
   always_comb begin
      mode_next = wdata_in[6:0];
      if (!wdata_in[BIT_WRITE_UNLOCK] && !unlock) begin
         // Locked: other bits may be cleared but never set.
         mode_next = wdata_in[6:0] & mode_reg;                            // RQ2
         mode_next[BIT_WRITE_UNLOCK] = 1'b0;
      end
      if (!unlock) begin
         // Unlock must already be 1 before any program or erase step sets.
         mode_next[5:0] = wdata_in[5:0] & mode_reg[5:0];                  // RQ1
      end
      if (!(mode_next[BIT_WRITE_UNLOCK] && mode_next[BIT_ERASE_SETUP]
            && mode_reg[BIT_ERASE_SETUP])) begin
         mode_next[BIT_ERASE_GO] = 1'b0;                                  // RQ9
      end
      if (!(mode_next[BIT_WRITE_UNLOCK] && mode_next[BIT_PROG_SETUP]
            && mode_reg[BIT_PROG_SETUP])) begin
         mode_next[BIT_PROG_GO] = 1'b0;                                   // RQ10
      end
      if (err_reg) begin
         mode_next[BIT_ERASE_GO] = 1'b0;                                  // RQ20
         mode_next[BIT_PROG_GO]  = 1'b0;                                  // RQ20
      end
   end

   // Mode control register; bits 5..0 are the setup, verify and go states.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_reg <= RST_MODE_CTRL[6:0];                                  // RQ19
      end else if (wr_mode) begin
         mode_reg <= mode_next;                                           // RQ3 RQ5 RQ7 RQ8
      end else if (err_reg) begin
         // Error protection drops any active program or erase at once.
         mode_reg[BIT_ERASE_GO] <= 1'b0;                                  // RQ12
         mode_reg[BIT_PROG_GO]  <= 1'b0;                                  // RQ12
      end
   end

   // Erase block select: cleared while locked or on a multi-bit write.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         eblk_reg <= RST_ERASE_BLOCK;
      end else if (!unlock) begin
         eblk_reg <= RST_ERASE_BLOCK;                                     // RQ17 RQ2
      end else if (wr_eblk) begin
         eblk_reg <= multi_sel ? RST_ERASE_BLOCK : wdata_in[EBLK_W-1:0];  // RQ18
      end
   end

   // Fault input comes from the flash array's timing, outside this domain.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fault_s1_reg <= 1'b0;
         fault_s2_reg <= 1'b0;
      end else begin
         fault_s1_reg <= flash_fault_in;
         fault_s2_reg <= fault_s1_reg;
      end
   end

   // A fault counts only while a program or erase is running; software can
   // also force one through the inject register to test the protection path.
   assign error_event = (fault_s2_reg & (mode_reg[BIT_ERASE_GO] | mode_reg[BIT_PROG_GO]))
                      | (wr_gated & (addr_in == OFF_ERR_INJECT) & wdata_in[0]);

   // Error flag is sticky until reset; writes to the status offset do nothing.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         err_reg <= 1'b0;                                                 // RQ19
      end else if (error_event) begin
         err_reg <= 1'b1;                                                 // RQ11
      end
   end

   // Access gate and power control registers.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gate_reg <= 1'b0;
         pwr_reg  <= 1'b0;
      end else begin
         if (wr_in && addr_in == OFF_ACCESS_GATE) begin
            gate_reg <= wdata_in[BIT_UNLOCK_REGS];
         end
         if (wr_gated && addr_in == OFF_POWER_CTRL) begin
            pwr_reg <= wdata_in[BIT_PDOWN_DIS];
         end
      end
   end

   // Read data stands only in the cycle after the strobe; gated registers
   // read zero while the gate is closed.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= READ_UNMAPPED;
      end else if (rd_in) begin
         case (addr_in)
            OFF_MODE_CTRL:   rdata_out <= gated_read(gate_reg, {1'b0, mode_reg});  // RQ14 RQ16
            OFF_ERR_STATUS:  rdata_out <= gated_read(gate_reg, {err_reg, 7'h00});  // RQ15 RQ16
            OFF_ERASE_BLOCK: rdata_out <= gated_read(gate_reg, {1'b0, eblk_reg});
            OFF_POWER_CTRL:  rdata_out <= gated_read(gate_reg, {pwr_reg, 7'h00});
            OFF_ACCESS_GATE: rdata_out <= {gate_reg, 7'h00};
            default:         rdata_out <= READ_UNMAPPED;
         endcase
      end else begin
         rdata_out <= READ_UNMAPPED;
      end
   end

   // Registered state outputs toward the flash array.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         erase_setup_out        <= 1'b0;
         program_setup_out      <= 1'b0;
         erase_verify_out       <= 1'b0;
         program_verify_out     <= 1'b0;
         erase_mode_out         <= 1'b0;
         program_mode_out       <= 1'b0;
         erase_block_out        <= RST_ERASE_BLOCK;
         error_protect_out      <= 1'b0;
         power_down_disable_out <= 1'b0;
      end else begin
         erase_setup_out        <= mode_reg[BIT_ERASE_SETUP];
         program_setup_out      <= mode_reg[BIT_PROG_SETUP];
         erase_verify_out       <= mode_reg[BIT_ERASE_VERIFY];
         program_verify_out     <= mode_reg[BIT_PROG_VERIFY];
         erase_mode_out         <= mode_reg[BIT_ERASE_GO] & ~err_reg;     // RQ20
         program_mode_out       <= mode_reg[BIT_PROG_GO] & ~err_reg;      // RQ20
         erase_block_out        <= eblk_reg;
         error_protect_out      <= err_reg;                               // RQ12
         power_down_disable_out <= pwr_reg;
      end
   end
endmodule
`default_nettype wire

// ==== fpec_ctrl_sva.sv ====
// Assertion checker for the flash program/erase control block.
// Assumes it is bound to fpec_ctrl and sees only that module's ports.
`default_nettype none
module fpec_ctrl_sva
   import fpec_pkg::*;
(
   input wire logic              mclk_in,
   input wire logic              rst_n_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic              rd_in,
   input wire logic [DATA_W-1:0] rdata_out,
   input wire logic              erase_setup_out,
   input wire logic              program_setup_out,
   input wire logic              erase_mode_out,
   input wire logic              program_mode_out,
   input wire logic [EBLK_W-1:0] erase_block_out,
   input wire logic              error_protect_out
);
   // One clock domain, so clock and reset are given once for all checks.
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   a_rdata_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data not zero outside a read answer");
   a_mode_bit7_zero: assert property ($past(rd_in) && $past(addr_in) == OFF_MODE_CTRL
      |-> rdata_out[7] == 1'b0) else $error("mode control bit 7 read as one");
   a_status_low_zero: assert property ($past(rd_in) && $past(addr_in) == OFF_ERR_STATUS
      |-> rdata_out[6:0] == 7'h00) else $error("status low bits not zero");
   a_erase_go_setup: assert property ($rose(erase_mode_out) |-> $past(erase_setup_out))
      else $error("erase mode entered without erase setup");
   a_prog_go_setup: assert property ($rose(program_mode_out) |-> $past(program_setup_out))
      else $error("program mode entered without program setup");
   a_protect_no_mode: assert property (error_protect_out
      |-> !erase_mode_out && !program_mode_out) else $error("mode active under error protection");
   a_protect_sticky: assert property (error_protect_out |=> error_protect_out [*3])
      else $error("error protection dropped without reset");
   a_block_onehot: assert property ($onehot0(erase_block_out))
      else $error("more than one erase block selected");
endmodule
bind fpec_ctrl fpec_ctrl_sva chk_u (.mclk_in, .rst_n_in, .addr_in, .rd_in, .rdata_out,
   .erase_setup_out, .program_setup_out, .erase_mode_out, .program_mode_out,
   .erase_block_out, .error_protect_out);
`default_nettype wire

// ==== flash_program_erase_control_bench.sv ====
// Self-checking bench for the flash program/erase control block.
// Assumes fpec_ctrl with its checker bound; the bench acts as the register master.
`default_nettype none
module flash_program_erase_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import fpec_pkg::*;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [2:0] addr_in = 3'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic flash_fault_in = 1'b0;
   logic [7:0] rdata_out;
   logic es, ps, ev, pv, em, pm, ep, pd;
   logic [6:0] eb;
   logic [14:0] outs_seen;
   int miscompares = 0;
   int tests_run = 0;
   // Pairs of written value and expected read-back, high byte written.
   logic [15:0] seq [15] = '{16'h3f00, 16'h4040, 16'h4240, 16'h6060, 16'h6262, 16'h6060,
      16'h4040, 16'h5050, 16'h5151, 16'h5050, 16'h4040, 16'hc848, 16'h4444, 16'h4040,
      16'h0000};
   // Free-running 125 MHz clock.
   always #4 mclk_in = ~mclk_in;
   fpec_ctrl dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .flash_fault_in(flash_fault_in),
      .rdata_out(rdata_out), .erase_setup_out(es), .program_setup_out(ps),
      .erase_verify_out(ev), .program_verify_out(pv), .erase_mode_out(em),
      .program_mode_out(pm), .erase_block_out(eb), .error_protect_out(ep),
      .power_down_disable_out(pd));
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      // One idle edge, so a following write never re-raises the strobe in this step.
      wr_in <= 1'b0;
      @(posedge mclk_in);
   endtask
   // Read answer and all level outputs are sampled a little after the edge, once settled.
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] got;
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 got = rdata_out;
      outs_seen = {ep, pd, eb, es, ps, ev, pv, em, pm};
      @(posedge mclk_in);
      check("read data", exp, got);
   endtask
   task automatic mode(input logic [7:0] d, input logic [7:0] exp);
      wr(OFF_MODE_CTRL, d);
      rd(OFF_MODE_CTRL, exp);
      check("mode outputs", {2'b00, exp[5:0]}, {2'b00, outs_seen[5:0]});
   endtask
   task automatic complete_run;
      if (miscompares == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Main sequence; a second reset in mid-run must clear the error flag again.
   initial begin
      repeat (3) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      @(posedge mclk_in);
      wr(OFF_MODE_CTRL, 8'h40);
      wr(OFF_ACCESS_GATE, 8'h80);
      rd(OFF_ACCESS_GATE, 8'h80);
      rd(OFF_MODE_CTRL, 8'h00);
      rd(OFF_ERR_STATUS, 8'h00);
      for (int i = 0; i < 14; i++) mode(seq[i][15:8], seq[i][7:0]);
      wr(OFF_ERASE_BLOCK, 8'h01);
      rd(OFF_ERASE_BLOCK, 8'h01);
      wr(OFF_ERASE_BLOCK, 8'h03);
      rd(OFF_ERASE_BLOCK, 8'h00);
      wr(OFF_ERASE_BLOCK, 8'h40);
      rd(OFF_ERASE_BLOCK, 8'h40);
      check("block output", 8'h40, {1'b0, outs_seen[12:6]});
      mode(seq[14][15:8], seq[14][7:0]);
      rd(OFF_ERASE_BLOCK, 8'h00);
      wr(OFF_ERASE_BLOCK, 8'h01);
      rd(OFF_ERASE_BLOCK, 8'h00);
      check("block output", 8'h00, {1'b0, outs_seen[12:6]});
      wr(OFF_POWER_CTRL, 8'h80);
      rd(OFF_POWER_CTRL, 8'h80);
      check("power output", 8'h01, {7'h00, outs_seen[13]});
      rd(3'h6, READ_UNMAPPED);
      wr(3'h6, 8'h80);
      rd(OFF_ERR_STATUS, 8'h00);
      for (int i = 6; i < 9; i++) mode(seq[i][15:8], seq[i][7:0]);
      flash_fault_in <= 1'b1;
      repeat (6) @(posedge mclk_in);
      flash_fault_in <= 1'b0;
      rd(OFF_ERR_STATUS, 8'h80);
      check("protect output", 8'h01, {7'h00, outs_seen[14]});
      mode(8'h51, 8'h50);
      wr(OFF_ACCESS_GATE, 8'h00);
      rd(OFF_ERR_STATUS, 8'h00);
      rst_n_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      @(posedge mclk_in);
      wr(OFF_ACCESS_GATE, 8'h80);
      rd(OFF_ERR_STATUS, 8'h00);
      check("protect output", 8'h00, {7'h00, outs_seen[14]});
      wr(OFF_ERR_INJECT, 8'h01);
      rd(OFF_ERR_STATUS, 8'h80);
      check("protect output", 8'h01, {7'h00, outs_seen[14]});
      complete_run();
   end
endmodule
`default_nettype wire
